//--- pis_pkg.sv
package pis_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] CFG_ROUTE_AB = 8'h5C;
  localparam logic [7:0] CFG_ROUTE_CD = 8'h5D;
  localparam logic [11:0] IO_TRIG_LOW = 12'h4D0;
  localparam logic [11:0] IO_TRIG_HIGH = 12'h4D1;
  localparam logic [7:0] ROUTE_RESET = 8'h00;
  localparam logic [7:0] TRIG_RESET = 8'h00;

  // ----------------------------------------------------------------
  // field layout
  // ----------------------------------------------------------------
  localparam int LO_FIELD_LSB = 0;
  localparam int HI_FIELD_LSB = 4;
  localparam logic [3:0] CODE_DISABLE = 4'h0;
  localparam logic [3:0] CODE_RESERVED_CODE_A = 4'h2;
  localparam logic [3:0] CODE_RESERVED_CODE_B = 4'h8;
  localparam logic [3:0] CODE_RESERVED_CODE_C = 4'hD;
  // writable bits of the sensitivity registers, reserved bits stay zero
  localparam logic [7:0] TRIG_LOW_MASK = 8'hFA;
  localparam logic [7:0] TRIG_HIGH_MASK = 8'hDE;
  localparam int NUM_PCI = 4;
  localparam int NUM_IRQ = 16;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] index;
    logic [7:0] wdata;
  } pis_cfg_req_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [11:0] addr;
    logic [7:0] wdata;
  } pis_io_req_t;

endpackage

//--- pis_route_decode.sv
`timescale 1ns/1ps
// ------------------------------------------------------------------
// one steering field decoded to a one-hot irq vector
// ------------------------------------------------------------------
module pis_route_decode (
  input wire logic [3:0] code,
  input wire logic active,
  output logic [pis_pkg::NUM_IRQ-1:0] onehot
);
  import pis_pkg::*;

  // reserved codes act like disable
  always_comb begin
    onehot = '0;
    if (active && code != CODE_DISABLE && code != CODE_RESERVED_CODE_A &&
        code != CODE_RESERVED_CODE_B && code != CODE_RESERVED_CODE_C) begin
      onehot[code] = 1'b1;
    end
  end
endmodule

//--- pis_top.sv
`timescale 1ns/1ps
// Operation
// - each of four pci lines routes to a selectable irq input.
// - routed irq still sees its own external irq pin.
// - pci lines are active low; routed request is inverted to high.
// - every irq defaults to positive edge triggering.
// - each irq except 0, 2, 8, 13 individually selectable as edge or level.
// - global level bit from first init word forces all irqs level.
// - 4-bit fields; 0 disables, codes 2, 8, 13 reserved, else irq number.
// - low sensitivity register covers irqs 7,6,5,4,3,1; bits 2,0 zero.
// - high register bits 7,6,4 cover irqs 15,14,12; bit 5 zero.
// - high register bits 3,2,1 cover irqs 11,10,9; bit 0 zero.
// - reset clears steering and sensitivity registers.
module pis_top (
  input wire logic REF_CLK,
  input wire logic RSTN,
  input wire pis_pkg::pis_cfg_req_t CFG_REQ,
  input wire pis_pkg::pis_io_req_t IO_REQ,
  input wire logic [pis_pkg::NUM_PCI-1:0] PCI_IRQ_LINE_N,
  input wire logic [pis_pkg::NUM_IRQ-1:0] EXT_IRQ,
  input wire logic LEVEL_ALL,
  output logic [7:0] CFG_RDATA,
  output logic [7:0] IO_RDATA,
  output logic [pis_pkg::NUM_IRQ-1:0] IRQ_REQ,
  output logic [pis_pkg::NUM_IRQ-1:0] IRQ_LEVEL
);
  import pis_pkg::*;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] route_ab_reg, route_ab_next;
  logic [7:0] route_cd_reg, route_cd_next;
  logic [7:0] trig_lo_reg, trig_lo_next;
  logic [7:0] trig_hi_reg, trig_hi_next;
  logic [7:0] cfg_rdata_next, io_rdata_next;
  logic [NUM_IRQ-1:0] irq_req_next, irq_level_next;
  logic [NUM_IRQ-1:0] hot_a, hot_b, hot_c, hot_d;

  // field extraction shared by the four decoders
  function automatic logic [3:0] field(input logic [7:0] r,
                                       input int lsb);
    field = r[lsb +: 4];
  endfunction

  // register writes and read mux
  always_comb begin
    route_ab_next = route_ab_reg;
    route_cd_next = route_cd_reg;
    trig_lo_next = trig_lo_reg;
    trig_hi_next = trig_hi_reg;
    cfg_rdata_next = CFG_RDATA;
    io_rdata_next = IO_RDATA;
    if (CFG_REQ.wr) begin
      if (CFG_REQ.index == CFG_ROUTE_AB) route_ab_next = CFG_REQ.wdata;
      if (CFG_REQ.index == CFG_ROUTE_CD) route_cd_next = CFG_REQ.wdata;
    end
    if (IO_REQ.wr) begin
      if (IO_REQ.addr == IO_TRIG_LOW)
        trig_lo_next = IO_REQ.wdata & TRIG_LOW_MASK;
      if (IO_REQ.addr == IO_TRIG_HIGH)
        trig_hi_next = IO_REQ.wdata & TRIG_HIGH_MASK;
    end
    if (CFG_REQ.rd) begin
      case (CFG_REQ.index)
        CFG_ROUTE_AB: cfg_rdata_next = route_ab_reg;
        CFG_ROUTE_CD: cfg_rdata_next = route_cd_reg;
        default: cfg_rdata_next = 8'h00;
      endcase
    end
    if (IO_REQ.rd) begin
      case (IO_REQ.addr)
        IO_TRIG_LOW: io_rdata_next = trig_lo_reg;
        IO_TRIG_HIGH: io_rdata_next = trig_hi_reg;
        default: io_rdata_next = 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // steering
  // ----------------------------------------------------------------
  pis_route_decode u_dec_a (.code(field(route_ab_reg, LO_FIELD_LSB)),
    .active(~PCI_IRQ_LINE_N[0]), .onehot(hot_a));
  pis_route_decode u_dec_b (.code(field(route_ab_reg, HI_FIELD_LSB)),
    .active(~PCI_IRQ_LINE_N[1]), .onehot(hot_b));
  pis_route_decode u_dec_c (.code(field(route_cd_reg, LO_FIELD_LSB)),
    .active(~PCI_IRQ_LINE_N[2]), .onehot(hot_c));
  pis_route_decode u_dec_d (.code(field(route_cd_reg, HI_FIELD_LSB)),
    .active(~PCI_IRQ_LINE_N[3]), .onehot(hot_d));

  // merge pci requests (inverted above) with external pins
  always_comb begin
    irq_req_next = EXT_IRQ | hot_a | hot_b | hot_c | hot_d;
    // edge by default, per-irq level bit, global override
    irq_level_next = {trig_hi_reg, trig_lo_reg};
    if (LEVEL_ALL) irq_level_next = '1;
  end

  // state update
  always_ff @(posedge REF_CLK) begin
    if (!RSTN) begin
      route_ab_reg <= ROUTE_RESET;
      route_cd_reg <= ROUTE_RESET;
      trig_lo_reg <= TRIG_RESET;
      trig_hi_reg <= TRIG_RESET;
      CFG_RDATA <= 8'h00;
      IO_RDATA <= 8'h00;
      IRQ_REQ <= '0;
      IRQ_LEVEL <= '0;
    end else begin
      route_ab_reg <= route_ab_next;
      route_cd_reg <= route_cd_next;
      trig_lo_reg <= trig_lo_next;
      trig_hi_reg <= trig_hi_next;
      CFG_RDATA <= cfg_rdata_next;
      IO_RDATA <= io_rdata_next;
      IRQ_REQ <= irq_req_next;
      IRQ_LEVEL <= irq_level_next;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_route_a;
    @(posedge REF_CLK) disable iff (!RSTN)
    (!PCI_IRQ_LINE_N[0] && route_ab_reg[3:0] == 4'h5)
      |=> IRQ_REQ[5];
  endproperty
  a_route_a: assert property (p_route_a) else $error("inta not routed");

  property p_ext_kept;
    @(posedge REF_CLK) disable iff (!RSTN)
    EXT_IRQ[9] |=> IRQ_REQ[9];
  endproperty
  a_ext_kept: assert property (p_ext_kept) else $error("ext pin lost");

  property p_invert;
    @(posedge REF_CLK) disable iff (!RSTN)
    (PCI_IRQ_LINE_N == 4'hF && EXT_IRQ == '0) |=> IRQ_REQ == '0;
  endproperty
  a_invert: assert property (p_invert) else $error("idle line asserts");

  property p_level_all;
    @(posedge REF_CLK) disable iff (!RSTN)
    LEVEL_ALL |=> IRQ_LEVEL == 16'hFFFF;
  endproperty
  a_level_all: assert property (p_level_all) else $error("no override");

  property p_reserved_code;
    @(posedge REF_CLK) disable iff (!RSTN)
    (route_ab_reg[3:0] == 4'h8 && PCI_IRQ_LINE_N[3:1] == 3'h7 &&
     EXT_IRQ[8] == 1'b0) |=> !IRQ_REQ[8];
  endproperty
  a_reserved_code: assert property (p_reserved_code) else $error("reserved code routed");

  property p_lo_mask;
    @(posedge REF_CLK) disable iff (!RSTN)
    (IO_REQ.wr && IO_REQ.addr == IO_TRIG_LOW) |=> trig_lo_reg[2] == 1'b0 &&
      trig_lo_reg[0] == 1'b0 && trig_lo_reg[7] == $past(IO_REQ.wdata[7]);
  endproperty
  a_lo_mask: assert property (p_lo_mask) else $error("low sens bad");

  property p_hi_mask;
    @(posedge REF_CLK) disable iff (!RSTN)
    (IO_REQ.wr && IO_REQ.addr == IO_TRIG_HIGH) |=> trig_hi_reg[5] == 1'b0 &&
      trig_hi_reg[0] == 1'b0 && trig_hi_reg[1] == $past(IO_REQ.wdata[1]);
  endproperty
  a_hi_mask: assert property (p_hi_mask) else $error("high sens bad");

  property p_per_irq;
    @(posedge REF_CLK) disable iff (!RSTN)
    (!LEVEL_ALL && trig_hi_reg[7]) |=> IRQ_LEVEL[15];
  endproperty
  a_per_irq: assert property (p_per_irq) else $error("irq15 not level");

  // the other three lines reach their programmed targets
  property p_route_b;
    @(posedge REF_CLK) disable iff (!RSTN)
    (!PCI_IRQ_LINE_N[1] && route_ab_reg[7:4] == 4'h4)
      |=> IRQ_REQ[4];
  endproperty
  a_route_b: assert property (p_route_b) else $error("intb lost");

  property p_route_c;
    @(posedge REF_CLK) disable iff (!RSTN)
    (!PCI_IRQ_LINE_N[2] && route_cd_reg[3:0] == 4'hF)
      |=> IRQ_REQ[15];
  endproperty
  a_route_c: assert property (p_route_c) else $error("intc lost");

  property p_route_d;
    @(posedge REF_CLK) disable iff (!RSTN)
    (!PCI_IRQ_LINE_N[3] && route_cd_reg[7:4] == 4'h9)
      |=> IRQ_REQ[9];
  endproperty
  a_route_d: assert property (p_route_d) else $error("intd lost");

  // a disabled field drives nothing, whatever its own line does
  property p_disable;
    @(posedge REF_CLK) disable iff (!RSTN)
    (route_ab_reg[3:0] == CODE_DISABLE && PCI_IRQ_LINE_N[3:1] == 3'h7 &&
     EXT_IRQ == '0) |=> IRQ_REQ == '0;
  endproperty
  a_disable: assert property (p_disable) else $error("disabled routed");

  // cleared sensitivity registers leave every irq edge triggered
  property p_edge_dflt;
    @(posedge REF_CLK) disable iff (!RSTN)
    (!LEVEL_ALL && trig_lo_reg == TRIG_RESET && trig_hi_reg == TRIG_RESET)
      |=> IRQ_LEVEL == '0;
  endproperty
  a_edge_dflt: assert property (p_edge_dflt) else $error("not edge");

  // irqs 11, 10 and 9 keep the written select bits
  property p_hi_mid;
    @(posedge REF_CLK) disable iff (!RSTN)
    (IO_REQ.wr && IO_REQ.addr == IO_TRIG_HIGH) |=>
      trig_hi_reg[3:1] == $past(IO_REQ.wdata[3:1]);
  endproperty
  a_hi_mid: assert property (p_hi_mid) else $error("irq9-11 sens bad");

  property p_reset;
    @(posedge REF_CLK) !RSTN |=> route_ab_reg == 8'h00 &&
      route_cd_reg == 8'h00 && trig_lo_reg == 8'h00 && trig_hi_reg == 8'h00;
  endproperty
  a_reset: assert property (p_reset) else $error("reset not cleared");

  c_routed: cover property (@(posedge REF_CLK) disable iff (!RSTN)
    route_cd_reg[3:0] == 4'hF && !PCI_IRQ_LINE_N[2] ##1 IRQ_REQ[15]);
  c_level: cover property (@(posedge REF_CLK) disable iff (!RSTN)
    IRQ_LEVEL[3] && !LEVEL_ALL);
  c_cfg_rd: cover property (@(posedge REF_CLK) disable iff (!RSTN)
    CFG_REQ.rd && CFG_REQ.index == 8'h5D);
endmodule

//--- pis_pci_dev_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// pci devices sharing the four interrupt lines
// ----------------------------------------------------------------
module pis_pci_dev_model (
  input wire logic clk,
  input wire logic [3:0] assert_req,
  output logic [3:0] line_n
);
  // open drain with pull-up: a released line reads high, asserted low
  always_ff @(posedge clk) begin
    line_n <= ~assert_req;
  end
endmodule

//--- testbench.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// register access and steering tests
// ----------------------------------------------------------------
module testbench;
  import pis_pkg::*;
  logic REF_CLK, RSTN, LEVEL_ALL;
  pis_cfg_req_t cfg;
  pis_io_req_t io;
  logic [3:0] pci_n, dev_req;
  logic [15:0] ext, irq_req, irq_lvl;
  logic [7:0] cfg_rd, io_rd;
  int n_mismatch, check_count, cyc;

  pis_top dut (.REF_CLK(REF_CLK), .RSTN(RSTN), .CFG_REQ(cfg), .IO_REQ(io),
    .PCI_IRQ_LINE_N(pci_n), .EXT_IRQ(ext), .LEVEL_ALL(LEVEL_ALL),
    .CFG_RDATA(cfg_rd), .IO_RDATA(io_rd), .IRQ_REQ(irq_req),
    .IRQ_LEVEL(irq_lvl));
  pis_pci_dev_model pci (.clk(REF_CLK), .assert_req(dev_req),
    .line_n(pci_n));

  // free running clock
  initial begin
    REF_CLK = 1'b0;
    forever #20 REF_CLK = ~REF_CLK;
  end

  task final_report();
    if (n_mismatch == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // hang guard
  always @(posedge REF_CLK) begin
    cyc++;
    if (cyc == 1000) begin
      n_mismatch++;
      final_report();
    end
  end

  task chk(input logic [15:0] got, input logic [15:0] want);
    check_count++;
    if (got !== want) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, got, want);
    end
  endtask

  // one-cycle request pulse, launched and released on falling edges
  task acc(input bit is_io, input bit wr, input logic [11:0] a,
           input logic [7:0] d);
    @(negedge REF_CLK);
    if (is_io) io = '{wr, !wr, a, d};
    else cfg = '{wr, !wr, a[7:0], d};
    @(negedge REF_CLK);
    io = '0;
    cfg = '0;
  endtask

  task rd(input bit is_io, input logic [11:0] a, input logic [7:0] want);
    acc(is_io, 1'b0, a, 8'h00);
    chk({8'h00, is_io ? io_rd : cfg_rd}, {8'h00, want});
  endtask

  task settle();
    repeat (2) @(negedge REF_CLK);
  endtask

  // expected irq requests from steering codes and active-low lines
  function automatic logic [15:0] routed(input logic [15:0] codes,
                                         input logic [3:0] n);
    logic [3:0] c;
    routed = '0;
    for (int i = 0; i < 4; i++) begin
      c = codes[4*i+:4];
      if (!n[i] && !(c inside {4'h0, 4'h2, 4'h8, 4'hD})) routed[c] = 1'b1;
    end
  endfunction

  // main sequence
  initial begin
    RSTN = 1'b0;
    LEVEL_ALL = 1'b0;
    cfg = '0;
    io = '0;
    ext = '0;
    dev_req = '0;
    repeat (8) @(negedge REF_CLK);
    RSTN = 1'b1;
    rd(0, CFG_ROUTE_AB, ROUTE_RESET);
    rd(0, CFG_ROUTE_CD, ROUTE_RESET);
    rd(1, IO_TRIG_LOW, TRIG_RESET);
    rd(1, IO_TRIG_HIGH, TRIG_RESET);
    chk(irq_lvl, 16'h0000);
    acc(1, 1, IO_TRIG_LOW, 8'hFF);
    acc(1, 1, IO_TRIG_HIGH, 8'hFF);
    rd(1, IO_TRIG_LOW, 8'hFA);
    rd(1, IO_TRIG_HIGH, 8'hDE);
    rd(1, 12'h4D2, 8'h00);
    chk(irq_lvl, 16'hDEFA);
    LEVEL_ALL = 1'b1;
    settle();
    chk(irq_lvl, 16'hFFFF);
    LEVEL_ALL = 1'b0;
    acc(1, 1, IO_TRIG_LOW, 8'h18);
    settle();
    chk(irq_lvl, 16'hDE18);
    dev_req = 4'h1;
    for (int c = 0; c < 16; c++) begin
      acc(0, 1, CFG_ROUTE_AB, {4'h0, 4'(c)});
      settle();
      chk(irq_req, routed({12'h000, 4'(c)}, 4'hE));
    end
    dev_req = 4'h0;
    settle();
    chk(irq_req, 16'h0000);
    acc(0, 1, CFG_ROUTE_AB, 8'h43);
    acc(0, 1, CFG_ROUTE_CD, 8'h9F);
    rd(0, CFG_ROUTE_CD, 8'h9F);
    ext = 16'h0210;
    settle();
    chk(irq_req, 16'h0210);
    dev_req = 4'hF;
    ext = 16'h0020;
    settle();
    chk(irq_req, routed(16'h9F43, 4'h0) | 16'h0020);
    RSTN = 1'b0;
    @(negedge REF_CLK);
    RSTN = 1'b1;
    rd(0, CFG_ROUTE_AB, ROUTE_RESET);
    rd(1, IO_TRIG_HIGH, TRIG_RESET);
    final_report();
  end
endmodule
